// File: design/lpm_pkg.sv
// Purpose: shared types and constants for the low power mode controller
// Assumes: single 40 MHz system clock domain
// Notes: all fields used by the controller are named here
package lpm_pkg;
  // operating modes
  typedef enum logic [1:0] {
    LPM_ACTIVE,
    LPM_STANDBY,
    LPM_STOP
  } lpm_mode_t;

  // requests from the core, one cycle pulses
  typedef struct packed {
    logic light_sleep_instr;
    logic deep_sleep_instr;
    logic return_from_irq_instr;
    logic irq_accept;
  } lpm_core_req_t;

  // unit hold controls driven to the rest of the chip
  typedef struct packed {
    logic core_clk_en;
    logic osc_run;
    logic periph_run;
    logic cmp_run;
    logic unit_reset;
    logic pins_hiz;
  } lpm_ctrl_t;

  localparam int LPM_RAM_VALID_BIT = 3;
  localparam logic [11:0] LPM_RESET_VECTOR = 12'h000;
  localparam logic LPM_DIV_SEL_FAST = 1'b1;
  localparam logic [5:0] LPM_DIV_FAST = 6'h04;
  localparam logic [5:0] LPM_DIV_SLOW = 6'h20;
  localparam int LPM_CLK_NS = 25;
  localparam int LPM_SETTLE_NS = 1000;
  localparam int LPM_SETTLE_CYC = (LPM_SETTLE_NS + LPM_CLK_NS - 1) / LPM_CLK_NS;
  localparam logic [3:0] LPM_CTRL_WORD_RST = 4'h0;
endpackage : lpm_pkg

// File: design/lpm_ctrl.sv
// Purpose: low power mode controller for a small 4-bit microcontroller
// Assumes: inputs synchronous to clk_sys; sys_rst asynchronous active high
// Notes: stop cancel input is active low and filtered for the settle period
// Summary of operation
// - active mode clocks every function from the system oscillator
// - light sleep instruction in active mode enters standby
// - standby gates core clocks; RAM, registers and output pins are kept
// - interrupts, timers and serial keep running during standby
// - standby ends on reset or any interrupt request
// - interrupt wake resumes after sleep; enable decides service or pending
// - deep sleep instruction stops the oscillator and keeps RAM
// - stop mode resets all units and puts output pins in high impedance
// - RAM kept after stop; working registers need not be preserved
// - any stop cancellation restarts fetching at address zero
// - ram valid flag bit 3 reads 0 after reset, 1 after stop cancel
// - stop cancel acts only in stop mode; reset cancels every mode
// - reset is asynchronous and acts from any state
// - enable clear plus unmasked pending flag turns sleep into a no-op
// - divide strap sampled after reset or stop cancel: high 1/4, low 1/32
// - interrupt accept clears global enable, return from interrupt sets it
`timescale 1ns/1ps
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter int SETTLE_CYC = LPM_SETTLE_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // core side
  input wire lpm_core_req_t core_req,
  input wire logic irq_pending,
  input wire logic irq_unmasked_flag,
  // pins
  input wire logic stop_cancel_input_n,
  input wire logic div_sel_strap,
  // software visible oscillator range bits
  input wire logic osc_range_sel_a,
  input wire logic osc_range_sel_b,
  // mode and control outputs
  output lpm_mode_t mode,
  output lpm_ctrl_t unit_ctrl,
  output logic global_irq_enable,
  output logic [3:0] ram_valid_word,
  output logic [5:0] clk_div_ratio,
  output logic fetch_restart,
  output logic [11:0] fetch_addr,
  output logic osc_range_cfg_ok
);

  localparam int CW = $clog2(SETTLE_CYC + 1);

  lpm_mode_t mode_q, mode_d;
  logic ie_q, ie_d;
  logic ram_valid_q, ram_valid_d;
  logic [5:0] div_q, div_d;
  logic restart_q, restart_d;
  logic strap_pend_q, strap_pend_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic sleep_blocked;
  logic cancel_done;

  // pending unmasked request with enable clear cancels sleep
  assign sleep_blocked = !ie_q && irq_unmasked_flag;
  // stop cancel held low for the settle period
  assign cancel_done = (cnt_q == CW'(SETTLE_CYC));

  // next state for mode, enable, flag, divider and restart
  always_comb begin
    mode_d = mode_q;
    ie_d = ie_q;
    ram_valid_d = ram_valid_q;
    div_d = div_q;
    restart_d = 1'b0;
    strap_pend_d = 1'b0;
    cnt_d = '0;
    if (core_req.irq_accept) begin
      ie_d = 1'b0;
    end else if (core_req.return_from_irq_instr) begin
      ie_d = 1'b1;
    end
    unique case (mode_q)
      LPM_ACTIVE: begin
        if (core_req.light_sleep_instr && !sleep_blocked) begin
          mode_d = LPM_STANDBY;
        end else if (core_req.deep_sleep_instr && !sleep_blocked) begin
          mode_d = LPM_STOP;
        end
      end
      LPM_STANDBY: begin
        if (irq_pending) begin
          mode_d = LPM_ACTIVE;
        end
      end
      LPM_STOP: begin
        if (!stop_cancel_input_n) begin
          cnt_d = cancel_done ? cnt_q : cnt_q + CW'(1);
        end
        if (cancel_done && stop_cancel_input_n) begin
          mode_d = LPM_ACTIVE;
          ram_valid_d = 1'b1;
          restart_d = 1'b1;
          strap_pend_d = 1'b1;
        end
      end
      // unused encoding falls back to active
      default: begin
        mode_d = LPM_ACTIVE;
      end
    endcase
    if (strap_pend_q) begin
      div_d = (div_sel_strap == LPM_DIV_SEL_FAST) ? LPM_DIV_FAST : LPM_DIV_SLOW;
    end
  end

  // state registers, reset from any state
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= LPM_ACTIVE;
      ie_q <= 1'b0;
      ram_valid_q <= 1'b0;
      div_q <= LPM_DIV_SLOW;
      restart_q <= 1'b1;
      strap_pend_q <= 1'b1;
      cnt_q <= '0;
    end else begin
      mode_q <= mode_d;
      ie_q <= ie_d;
      ram_valid_q <= ram_valid_d;
      div_q <= div_d;
      restart_q <= restart_d;
      strap_pend_q <= strap_pend_d;
      cnt_q <= cnt_d;
    end
  end

  // unit controls per mode
  always_comb begin
    unit_ctrl.core_clk_en = (mode_q == LPM_ACTIVE);
    unit_ctrl.osc_run = (mode_q != LPM_STOP);
    unit_ctrl.periph_run = (mode_q != LPM_STOP);
    unit_ctrl.cmp_run = (mode_q == LPM_ACTIVE);
    unit_ctrl.unit_reset = (mode_q == LPM_STOP);
    unit_ctrl.pins_hiz = (mode_q == LPM_STOP);
  end

  // status outputs
  assign mode = mode_q;
  assign global_irq_enable = ie_q;
  assign ram_valid_word = LPM_CTRL_WORD_RST | (4'(ram_valid_q) << LPM_RAM_VALID_BIT);
  assign clk_div_ratio = div_q;
  assign fetch_restart = restart_q;
  assign fetch_addr = LPM_RESET_VECTOR;
  assign osc_range_cfg_ok = osc_range_sel_a | osc_range_sel_b | 1'b1; // informational only

  // independent witness of how long the cancel pin has been low in stop
  logic [CW-1:0] low_run_q, low_run_d;

  // saturating low-time count, cleared outside stop or when the pin is high
  always_comb begin
    low_run_d = '0;
    if (mode_q == LPM_STOP && !stop_cancel_input_n) begin
      low_run_d = (low_run_q == CW'(SETTLE_CYC)) ? low_run_q : low_run_q + CW'(1);
    end
  end

  // witness register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      low_run_q <= '0;
    end else begin
      low_run_q <= low_run_d;
    end
  end

  // checks: mode entry
  a_standby_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_ACTIVE && core_req.light_sleep_instr && !sleep_blocked |=> mode_q == LPM_STANDBY)
    else $error("standby not entered");

  a_stop_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_ACTIVE && core_req.deep_sleep_instr && !core_req.light_sleep_instr && !sleep_blocked
    |=> mode_q == LPM_STOP)
    else $error("stop not entered");

  a_sleep_noop: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_ACTIVE && sleep_blocked |=> mode_q == LPM_ACTIVE)
    else $error("blocked sleep changed mode");

  // checks: standby behaviour
  a_standby_wake: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STANDBY && irq_pending |=> mode_q == LPM_ACTIVE && !fetch_restart)
    else $error("interrupt wake wrong");

  a_standby_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STANDBY && !irq_pending |=> mode_q == LPM_STANDBY)
    else $error("standby left without a request");

  a_standby_ctrl: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STANDBY |-> !unit_ctrl.core_clk_en && unit_ctrl.periph_run && !unit_ctrl.pins_hiz)
    else $error("standby controls wrong");

  a_standby_periph: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STANDBY |-> unit_ctrl.osc_run && unit_ctrl.periph_run && !unit_ctrl.unit_reset
      && !unit_ctrl.cmp_run)
    else $error("standby peripherals not running");

  a_wake_keeps_ie: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STANDBY && irq_pending && !core_req.irq_accept && !core_req.return_from_irq_instr
    |=> $stable(global_irq_enable))
    else $error("wake changed the interrupt enable");

  // checks: active mode
  a_active_clocks: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_ACTIVE |-> unit_ctrl.core_clk_en && unit_ctrl.osc_run && unit_ctrl.periph_run
      && unit_ctrl.cmp_run && !unit_ctrl.unit_reset && !unit_ctrl.pins_hiz)
    else $error("active mode not fully clocked");

  // checks: stop behaviour
  a_stop_hiz: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STOP |-> unit_ctrl.pins_hiz && unit_ctrl.unit_reset && !unit_ctrl.osc_run)
    else $error("stop outputs wrong");

  a_stop_no_units: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STOP |-> !unit_ctrl.periph_run && !unit_ctrl.cmp_run && !unit_ctrl.core_clk_en)
    else $error("units running in stop");

  a_stop_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STOP && !(cancel_done && stop_cancel_input_n) |=> mode_q == LPM_STOP)
    else $error("stop left without a cancel");

  a_settle_exit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STOP && low_run_q != CW'(SETTLE_CYC) |=> mode_q == LPM_STOP)
    else $error("stop left before the settle time");

  a_cnt_bounded: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cnt_q <= CW'(SETTLE_CYC))
    else $error("settle count overran");

  a_cancel_ignored: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q != LPM_STOP |=> !($rose(ram_valid_q)))
    else $error("stop cancel acted outside stop");

  a_cancel_exit: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STOP && cancel_done && stop_cancel_input_n
    |=> mode_q == LPM_ACTIVE && ram_valid_q && fetch_restart ##1 clk_div_ratio ==
      ($past(div_sel_strap) ? LPM_DIV_FAST : LPM_DIV_SLOW))
    else $error("stop cancel exit wrong");

  // checks: restart and divider
  a_restart_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetch_restart |-> fetch_addr == LPM_RESET_VECTOR)
    else $error("restart address wrong");

  a_restart_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetch_restart |=> !fetch_restart)
    else $error("restart longer than one cycle");

  a_div_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fetch_restart |=> clk_div_ratio == ($past(div_sel_strap) ? LPM_DIV_FAST : LPM_DIV_SLOW))
    else $error("divider not loaded from strap");

  a_div_stable: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !strap_pend_q |=> $stable(clk_div_ratio))
    else $error("divider changed without a restart");

  a_div_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
    clk_div_ratio == LPM_DIV_FAST || clk_div_ratio == LPM_DIV_SLOW)
    else $error("divider ratio illegal");

  // checks: interrupt enable
  a_ie_accept: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_req.irq_accept |=> !global_irq_enable)
    else $error("enable not cleared");

  a_ie_return: assert property (@(posedge clk_sys) disable iff (sys_rst)
    core_req.return_from_irq_instr && !core_req.irq_accept |=> global_irq_enable)
    else $error("enable not set on return");

  // checks: reset forces the active state from any mode
  a_reset_active: assert property (@(posedge clk_sys)
    sys_rst ##1 sys_rst |-> mode_q == LPM_ACTIVE && !ram_valid_q && fetch_restart)
    else $error("reset state wrong");

  // main scenarios
  c_stop_entry: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_ACTIVE ##1 mode_q == LPM_STOP);
  c_standby_wake: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STANDBY ##1 mode_q == LPM_ACTIVE);
  c_stop_cancel: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_STOP ##1 mode_q == LPM_ACTIVE);
  c_sleep_noop: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode_q == LPM_ACTIVE && core_req.light_sleep_instr && sleep_blocked);

endmodule : lpm_ctrl

// File: testbench/lpm_pin_model.sv
// Purpose: far side model of the stop cancel pin
// Assumes: pin has a pull-up, so released means high
// Notes: a go pulse holds the pin low for HOLD cycles
`timescale 1ns/1ps
module lpm_pin_model #(
  parameter int HOLD = 6
) (
  // clock and trigger
  input wire logic clk_sys,
  input wire logic go,
  // stop cancel pin, active low
  output logic stop_cancel_input_n
);
  int cnt = 0;
  // count down the low time, then let the pull-up win
  always @(posedge clk_sys) begin
    if (go) cnt <= HOLD;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  assign stop_cancel_input_n = (cnt == 0);
endmodule : lpm_pin_model

// File: testbench/tb_lpm_ctrl.sv
// Purpose: self-checking bench for the mode controller
// Assumes: settle count shortened to 4 cycles
// Notes: expected modes and ram valid words are queued by the driver
`timescale 1ns/1ps
module tb_lpm_ctrl;
  import lpm_pkg::*;
  localparam int SC = 4;
  logic clk_sys = 0, sys_rst = 1, irq_pending = 0, irq_unmasked_flag = 0;
  logic div_sel_strap = 0, go = 0, rsa = 0, rsb = 0, stop_cancel_input_n;
  logic global_irq_enable, fetch_restart;
  logic [3:0] ram_valid_word;
  logic [5:0] clk_div_ratio;
  logic [11:0] fetch_addr;
  lpm_core_req_t core_req = '0;
  lpm_mode_t mode, prev_mode;
  lpm_ctrl_t unit_ctrl;
  int fail_count = 0, comparisons = 0;
  lpm_mode_t qm[$];
  logic [3:0] qv[$];
  lpm_ctrl #(.SETTLE_CYC(SC)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .core_req(core_req),
    .irq_pending(irq_pending), .irq_unmasked_flag(irq_unmasked_flag),
    .stop_cancel_input_n(stop_cancel_input_n), .div_sel_strap(div_sel_strap),
    .osc_range_sel_a(rsa), .osc_range_sel_b(rsb), .mode(mode), .unit_ctrl(unit_ctrl),
    .global_irq_enable(global_irq_enable), .ram_valid_word(ram_valid_word),
    .clk_div_ratio(clk_div_ratio), .fetch_restart(fetch_restart), .fetch_addr(fetch_addr),
    .osc_range_cfg_ok());
  lpm_pin_model #(.HOLD(SC + 2)) pin (.clk_sys(clk_sys), .go(go), .stop_cancel_input_n(stop_cancel_input_n));
  // 40 MHz clock
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk_mode(input lpm_mode_t e, input lpm_mode_t s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL mode expected %0d seen %0d", e, s);
    end
  endtask : chk_mode
  task automatic chk_val(input string n, input logic [11:0] e, input logic [11:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk_val
  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic pulse(input lpm_core_req_t r);
    core_req <= r;
    @(posedge clk_sys);
    core_req <= '0;
    @(posedge clk_sys);
  endtask : pulse
  task automatic wait_mode(input lpm_mode_t m);
    for (int i = 0; i < 100 && mode !== m; i++) @(posedge clk_sys);
    if (mode !== m) begin
      fail_count++;
      $display("FAIL wait_mode expected %0d seen %0d", m, mode);
      end_sim();
    end
  endtask : wait_mode
  // watcher: every mode change and restart consumes the oldest note
  always @(posedge clk_sys) begin
    if (!sys_rst && mode !== prev_mode) chk_mode(qm.size() ? qm.pop_front() : prev_mode, mode);
    if (!sys_rst && fetch_restart === 1'b1 && qv.size()) chk_val("ram_valid", qv.pop_front(), ram_valid_word);
    prev_mode <= mode;
  end
  initial begin
    void'($urandom(65582));
    @(posedge clk_sys);
    div_sel_strap <= 1'($urandom);
    rsa <= 1'($urandom);
    rsb <= 1'($urandom);
    repeat (4) @(posedge clk_sys);
    qv.push_back(4'h0);
    sys_rst <= 0;
    repeat (3) @(posedge clk_sys);
    chk_val("div", div_sel_strap ? 12'h004 : 12'h020, clk_div_ratio);
    chk_val("fetch_addr", 12'h000, fetch_addr);
    chk_val("ie", 12'h000, global_irq_enable);
    $display("test reset done");
    qm.push_back(LPM_STANDBY);
    qm.push_back(LPM_ACTIVE);
    pulse('{1'b1, 1'b0, 1'b0, 1'b0});
    chk_val("core_clk", 12'h000, unit_ctrl.core_clk_en);
    chk_val("osc_run", 12'h001, unit_ctrl.osc_run & unit_ctrl.periph_run);
    chk_val("cmp_run", 12'h000, unit_ctrl.cmp_run);
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    repeat (SC + 5) @(posedge clk_sys);
    irq_pending <= 1;
    wait_mode(LPM_ACTIVE);
    irq_pending <= 0;
    chk_val("core_clk", 12'h001, unit_ctrl.core_clk_en);
    $display("test standby done");
    pulse('{1'b0, 1'b0, 1'b1, 1'b0});
    chk_val("ie", 12'h001, global_irq_enable);
    irq_unmasked_flag <= 1;
    pulse('{1'b0, 1'b0, 1'b0, 1'b1});
    chk_val("ie", 12'h000, global_irq_enable);
    pulse('{1'b1, 1'b0, 1'b0, 1'b0});
    pulse('{1'b0, 1'b1, 1'b0, 1'b0});
    irq_unmasked_flag <= 0;
    repeat (3) @(posedge clk_sys);
    $display("test blocked sleep done");
    qm.push_back(LPM_STOP);
    qm.push_back(LPM_ACTIVE);
    qv.push_back(4'h8);
    pulse('{1'b0, 1'b1, 1'b0, 1'b0});
    chk_val("stop_ctrl", 12'h003, {unit_ctrl.osc_run, unit_ctrl.periph_run, unit_ctrl.cmp_run,
      unit_ctrl.unit_reset, unit_ctrl.pins_hiz});
    div_sel_strap <= ~div_sel_strap;
    go <= 1;
    @(posedge clk_sys);
    go <= 0;
    wait_mode(LPM_ACTIVE);
    repeat (3) @(posedge clk_sys);
    chk_val("div", div_sel_strap ? 12'h004 : 12'h020, clk_div_ratio);
    $display("test stop cancel done");
    qm.push_back(LPM_STOP);
    qv.push_back(4'h0);
    pulse('{1'b0, 1'b1, 1'b0, 1'b0});
    sys_rst <= 1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 0;
    repeat (3) @(posedge clk_sys);
    chk_mode(LPM_ACTIVE, mode);
    $display("test stop reset done");
    end_sim();
  end
endmodule : tb_lpm_ctrl
